// file: hpsh_device.sv
// hpsh_device: device end of the parallel host port
// assumes: host keeps the strobe and select timing; memory side is a
// simple fetch request/answer and a write stream with back-pressure
//
// What this block does
// - strobe = not(ds1 xor ds2) or chip select
// - host holds strobe until ready goes low
// - first-half data-register read fetches; ready high until loaded
// - ready high while write buffer is full, on writes that complete a data word
// - address strobe pulses at most once per strobe
// - selects sampled together as one group
// - sample at address strobe else strobe
// - address strobe falls before strobe falls
// - strobe low at least four periods
// - strobe high at least four periods
// - drive data only during reads
// - read data valid before ready low
// - second half-word needs no new fetch
// - 32-bit and 16-bit modes supported
`default_nettype none
module hpsh_device
    import hpsh_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // host pins
    hpsh_if.device port,
    // internal fetch port
    output logic fetch_req_o,
    input wire logic fetch_ack_i,
    input wire logic [31:0] fetch_data_i,
    // internal write stream
    output logic wr_valid_o,
    output logic [31:0] wr_data_o,
    input wire logic wr_ready_i
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [4:0] pins_s1_r;                          // first stage only
    logic [4:0] pins_s2_r;                          // stable copy
    logic strobe_d_r;                               // previous strobe
    logic as_d_r;                                   // previous address strobe
    wire raw_strobe_n = ~(port.data_strobe_one_n ^ port.data_strobe_two_n)
                        | port.port_chip_select_n;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pins_s1_r <= 5'h1F;
            pins_s2_r <= 5'h1F;
        end else begin
            pins_s1_r <= {raw_strobe_n, port.address_strobe_n, 3'h7};
            pins_s2_r <= pins_s1_r;
        end
    end
    wire strobe_n = pins_s2_r[4];
    wire as_n = pins_s2_r[3];
    wire strobe_fall = strobe_d_r && !strobe_n;
    wire strobe_rise = !strobe_d_r && strobe_n;
    wire as_fall = as_d_r && !as_n;
    // ------------------------------------------------------------
    // select capture
    // ------------------------------------------------------------
    logic as_used_r;                                // address strobe seen this access
    hpsh_sel_t sel_r;                               // captured group
    wire hpsh_sel_t sel_now = '{port.access_control_select, port.read_write_select,
                                port.halfword_identifier & port.halfword_bus_mode};
    wire take_sel = as_fall || (strobe_fall && !as_used_r);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            strobe_d_r <= 1'b1;
            as_d_r <= 1'b1;
            as_used_r <= 1'b0;
            sel_r <= '0;
        end else begin
            strobe_d_r <= strobe_n;
            as_d_r <= as_n;
            if (as_fall) as_used_r <= 1'b1;
            else if (strobe_rise) as_used_r <= 1'b0;
            if (take_sel) sel_r <= sel_now;
        end
    end
    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire is_read = sel_r.read_write_select;
    wire is_data = sel_r.access_control_select == CTL_DATA_REG;
    wire second_half = sel_r.halfword_identifier;
    wire hw_mode = port.halfword_bus_mode;
    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_FETCH = 5'b00010,
        ST_DRIVE = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_DONE = 5'b10000
    } hpsh_state_t;
    hpsh_state_t state_r, state_nxt;
    logic [31:0] data_reg_r;                        // port data register
    logic [15:0] low_half_r;                        // first half of a write
    logic [31:0] dout_r;
    logic oe_n_r;
    logic rdy_n_r;
    logic fetch_r;
    logic wb_valid_r;
    logic [31:0] wb_data_r;
    wire wb_ready;
    wire [31:0] wr_word = hw_mode ? {port.bus_data[15:0], low_half_r} : port.bus_data;
    // start of an access, one cycle after the fall so selects are in
    logic start_r;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (start_r) begin
                    if (is_read && is_data && !second_half) state_nxt = ST_FETCH;
                    else if (is_read) state_nxt = ST_DRIVE;
                    else state_nxt = ST_WRITE;
                end
            ST_FETCH: if (fetch_ack_i) state_nxt = ST_DRIVE;
            ST_DRIVE: state_nxt = ST_DONE;
            // first half only latches; a full word waits for buffer space
            ST_WRITE: if (!is_data || (hw_mode && !second_half) || (wb_ready && !wb_valid_r))
                state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_DONE;
        endcase
        if (strobe_rise) state_nxt = ST_IDLE;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= ST_IDLE;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= strobe_fall;
        end
    end
    // ------------------------------------------------------------
    // data register, bus drive and ready
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            data_reg_r <= DATA_RST;
            low_half_r <= '0;
            dout_r <= '0;
            oe_n_r <= 1'b1;
            rdy_n_r <= 1'b1;
            fetch_r <= 1'b0;
            wb_valid_r <= 1'b0;
            wb_data_r <= '0;
        end else begin
            fetch_r <= (state_nxt == ST_FETCH);
            if (state_r == ST_FETCH && fetch_ack_i) data_reg_r <= fetch_data_i;
            // drive only between strobe fall and rise on reads
            oe_n_r <= !(is_read && !strobe_n && state_r != ST_IDLE);
            if (state_r == ST_DRIVE) begin
                dout_r <= hw_mode ? {16'h0000, second_half ? data_reg_r[31:16]
                                                           : data_reg_r[15:0]}
                                  : data_reg_r;
            end
            // ready low one cycle after data placed
            rdy_n_r <= !(state_r == ST_DONE && !strobe_n);
            if (wb_valid_r && wb_ready) wb_valid_r <= 1'b0;
            if (state_r == ST_WRITE && is_data && strobe_rise == 1'b0) begin
                if (hw_mode && !second_half) low_half_r <= port.bus_data[15:0];
                else if (wb_ready && !wb_valid_r) begin
                    wb_valid_r <= 1'b1;
                    wb_data_r <= wr_word;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    hpsh_fifo #(.WIDTH(DATA_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(wb_valid_r),
        .in_data_i(wb_data_r),
        .in_ready_o(wb_ready),
        .out_valid_o(wr_valid_o),
        .out_data_o(wr_data_o),
        .out_ready_i(wr_ready_i)
    );
    assign port.dev_data_o = dout_r;
    assign port.dev_data_oe_n = oe_n_r;
    assign port.port_ready_n = rdy_n_r;
    assign fetch_req_o = fetch_r;
endmodule : hpsh_device
`default_nettype wire

// file: hpsh_pkg.sv
// hpsh_pkg: shared constants and types for the parallel host port
// assumes: single 50 MHz clock, synchronous active-high reset
`default_nettype none
package hpsh_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 20000;           // 50 MHz
    localparam int STROBE_LOW_MIN_PS = 12500;       // absolute floor of strobe low
    localparam int STROBE_LOW_MIN_P = 4;            // strobe low, in cpu periods
    localparam int STROBE_HIGH_MIN_P = 4;           // strobe high, in cpu periods
    localparam int STROBE_ABS_CYC = (STROBE_LOW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_LOW_CYC =
        (STROBE_ABS_CYC > STROBE_LOW_MIN_P) ? STROBE_ABS_CYC : STROBE_LOW_MIN_P;
    localparam int STROBE_HIGH_CYC = STROBE_HIGH_MIN_P;
    // ------------------------------------------------------------
    // widths and buffer
    // ------------------------------------------------------------
    localparam int DATA_W = 32;                     // host data bus width
    localparam int HALF_W = 16;                     // half-word width
    localparam int CTL_W = 2;                       // access-control field width
    localparam int WBUF_DEPTH = 8;                  // write buffer depth
    localparam int FETCH_LAT_CYC = 3;               // internal fetch latency model
    // ------------------------------------------------------------
    // access-control codes
    // ------------------------------------------------------------
    localparam logic [1:0] CTL_DATA_REG = 2'h3;     // data register access
    localparam logic [31:0] DATA_RST = 32'h0000_0000; // reset value of data register
    // ------------------------------------------------------------
    // select group sampled together
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] access_control_select;
        logic read_write_select;                    // 1 = read
        logic halfword_identifier;                  // 1 = second half-word
    } hpsh_sel_t;
endpackage : hpsh_pkg
`default_nettype wire

// file: hpsh_if.sv
// hpsh_if: pins between host and device ends
// assumes: testbench joins both modports; the interface resolves the data bus
`default_nettype none
interface hpsh_if;
    import hpsh_pkg::*;
    // host-driven pins
    logic port_chip_select_n;
    logic data_strobe_one_n;
    logic data_strobe_two_n;
    logic address_strobe_n;
    logic [1:0] access_control_select;
    logic read_write_select;
    logic halfword_identifier;
    logic halfword_bus_mode;                        // 1 = 16-bit mode
    // device-driven ready
    logic port_ready_n;
    // data bus as three signals per end
    logic [31:0] host_data_o;
    logic host_data_oe_n;                           // low = host drives
    logic [31:0] dev_data_o;
    logic dev_data_oe_n;                            // low = device drives
    logic [31:0] bus_data;                          // resolved level
    assign bus_data = !dev_data_oe_n ? dev_data_o :
                      (!host_data_oe_n ? host_data_o : 32'hFFFF_FFFF);
    modport device (
        input port_chip_select_n, data_strobe_one_n, data_strobe_two_n,
        input address_strobe_n, access_control_select, read_write_select,
        input halfword_identifier, halfword_bus_mode, bus_data,
        output port_ready_n, dev_data_o, dev_data_oe_n
    );
    modport host (
        output port_chip_select_n, data_strobe_one_n, data_strobe_two_n,
        output address_strobe_n, access_control_select, read_write_select,
        output halfword_identifier, halfword_bus_mode, host_data_o, host_data_oe_n,
        input port_ready_n, bus_data
    );
endinterface : hpsh_if
`default_nettype wire

// file: hpsh_fifo.sv
// hpsh_fifo: synchronous valid/ready fifo, used as device write buffer
// assumes: one clock, synchronous active-high reset
`default_nettype none
module hpsh_fifo
    import hpsh_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];                  // storage
    logic [AW-1:0] wr_ptr_r;                        // write pointer
    logic [AW-1:0] rd_ptr_r;                        // read pointer
    logic [AW:0] count_r;                           // words held
    wire do_push = in_valid_i && in_ready_o;
    wire do_pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem[rd_ptr_r];
    // ------------------------------------------------------------
    // pointers and count
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) wr_ptr_r <= AW'((wr_ptr_r == AW'(DEPTH-1)) ? 0 : wr_ptr_r + 1'b1);
            if (do_pop) rd_ptr_r <= AW'((rd_ptr_r == AW'(DEPTH-1)) ? 0 : rd_ptr_r + 1'b1);
            count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
    // storage write
    always_ff @(posedge clk_i) begin
        if (do_push) mem[wr_ptr_r] <= in_data_i;
    end
endmodule : hpsh_fifo
`default_nettype wire

// file: hpsh_host.sv
// hpsh_host: host end, runs one access per request with legal timing
// assumes: device end on the same clock via the interface
`default_nettype none
module hpsh_host
    import hpsh_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // user request
    input wire logic req_i,
    input wire logic req_read_i,
    input wire logic [1:0] req_ctl_i,
    input wire logic req_half_i,
    input wire logic req_hw_mode_i,
    input wire logic req_use_as_i,
    input wire logic [31:0] req_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] rd_data_o,
    // pins
    hpsh_if.host port
);
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001, HS_AS = 4'b0010, HS_LOW = 4'b0100, HS_HIGH = 4'b1000
    } hpsh_hstate_t;
    hpsh_hstate_t st_r;
    logic [7:0] cnt_r;
    logic [1:0] rdy_s_r;                            // ready synchroniser
    logic ds_r, as_r, oe_n_r, done_r;
    logic rd_r, hw_r, half_r, asu_r;
    logic [1:0] ctl_r;
    logic [31:0] dat_r, rdd_r;
    wire rdy_low = !rdy_s_r[1];
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= HS_IDLE; cnt_r <= '0; rdy_s_r <= 2'h3; ds_r <= 1'b1; as_r <= 1'b1;
            oe_n_r <= 1'b1; done_r <= 1'b0; rd_r <= 1'b0; hw_r <= 1'b0; half_r <= 1'b0;
            asu_r <= 1'b0; ctl_r <= '0; dat_r <= '0; rdd_r <= '0;
        end else begin
            rdy_s_r <= {rdy_s_r[0], port.port_ready_n};
            done_r <= 1'b0;
            cnt_r <= (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
            unique case (st_r)
                HS_IDLE: if (req_i) begin
                    rd_r <= req_read_i; ctl_r <= req_ctl_i; hw_r <= req_hw_mode_i;
                    half_r <= req_half_i; asu_r <= req_use_as_i; dat_r <= req_data_i;
                    oe_n_r <= req_read_i;
                    if (req_use_as_i) begin
                        as_r <= 1'b0; st_r <= HS_AS;
                    end else begin
                        ds_r <= 1'b0; st_r <= HS_LOW;
                        cnt_r <= 8'(STROBE_LOW_CYC);
                    end
                end
                HS_AS: begin
                    ds_r <= 1'b0; st_r <= HS_LOW; cnt_r <= 8'(STROBE_LOW_CYC);
                end
                HS_LOW: begin
                    if (cnt_r == 8'h00) as_r <= 1'b1;
                    if (cnt_r == 8'h00 && rdy_low) begin
                        ds_r <= 1'b1; oe_n_r <= 1'b1; rdd_r <= port.bus_data;
                        done_r <= 1'b1; st_r <= HS_HIGH; cnt_r <= 8'(STROBE_HIGH_CYC);
                    end
                end
                HS_HIGH: if (cnt_r == 8'h00) st_r <= HS_IDLE;
            endcase
        end
    end
    // chip select held low, strobe two parked high, strobe one toggles
    assign port.port_chip_select_n = 1'b0;
    assign port.data_strobe_one_n = ds_r;
    assign port.data_strobe_two_n = 1'b1;
    assign port.address_strobe_n = as_r;
    assign port.access_control_select = ctl_r;
    assign port.read_write_select = rd_r;
    assign port.halfword_identifier = half_r;
    assign port.halfword_bus_mode = hw_r;
    assign port.host_data_o = dat_r;
    assign port.host_data_oe_n = oe_n_r;
    assign busy_o = (st_r != HS_IDLE);
    assign done_o = done_r;
    assign rd_data_o = rdd_r;
endmodule : hpsh_host
`default_nettype wire

// file: hpsh_props.sv
// hpsh_props: timing checks on the pins between host and device ends
// assumes: placed beside the interface, one clock, sync reset
`default_nettype none
module hpsh_props
    import hpsh_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // host-driven pins
    input wire logic port_chip_select_n,
    input wire logic data_strobe_one_n,
    input wire logic data_strobe_two_n,
    input wire logic [1:0] access_control_select,
    input wire logic read_write_select,
    input wire logic halfword_identifier,
    input wire logic halfword_bus_mode,
    // device-driven pins
    input wire logic port_ready_n,
    input wire logic [31:0] dev_data_o,
    input wire logic dev_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // combined strobe, active low
    // ------------------------------------------------------------
    logic strb_n;
    assign strb_n = ~(data_strobe_one_n ^ data_strobe_two_n) | port_chip_select_n;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_idle_float;
        strb_n [*7] |-> dev_data_oe_n && port_ready_n;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("bus driven or ready low while strobe idle");
    property p_sync_delay;
        $fell(strb_n) |-> (port_ready_n && dev_data_oe_n) [*2];
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("answer came before strobe was synchronised");
    property p_ready_rise;
        $rose(port_ready_n) |-> strb_n && $past(strb_n, 2);
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready released while strobe still low");
    property p_read_valid;
        (!port_ready_n && !strb_n && read_write_select) |-> !dev_data_oe_n;
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("ready low on a read without data driven");
    property p_data_hold;
        (!port_ready_n && $past(!port_ready_n) && !dev_data_oe_n) |-> $stable(dev_data_o);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read data changed while ready low");
    property p_write_float;
        (!strb_n && !read_write_select) [*4] |-> dev_data_oe_n;
    endproperty
    a_write_float: assert property (p_write_float)
        else $error("device drove the bus during a write");
    property p_half_two;
        ($fell(strb_n) && halfword_bus_mode && halfword_identifier && read_write_select
            && access_control_select == CTL_DATA_REG) |-> ##[1:8] (!port_ready_n && !dev_data_oe_n);
    endproperty
    a_half_two: assert property (p_half_two)
        else $error("second half-word not served promptly");
    property p_rd_only_drive;
        $fell(dev_data_oe_n) |-> read_write_select && !strb_n;
    endproperty
    a_rd_only_drive: assert property (p_rd_only_drive)
        else $error("drivers enabled outside a read strobe");
endmodule : hpsh_props
`default_nettype wire

// file: hpsh_tb_top.sv
// hpsh_tb_top: host end facing device end, user side driven by tasks
// assumes: package, interface, fifo, host and device compiled before
`default_nettype none
module hpsh_tb_top;
    import hpsh_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_i = 1'b0, req_read_i = 1'b0, req_half_i = 1'b0;
    logic req_hw_mode_i = 1'b0, req_use_as_i = 1'b0;
    logic [1:0] req_ctl_i = 2'h0;
    logic [31:0] req_data_i = 32'h0, rd_data_o, wr_data_o, fword = 32'h0;
    logic busy_o, done_o, fetch_req_o, wr_valid_o;
    logic fetch_ack_i = 1'b0, wr_ready_i = 1'b1, stall = 1'b0;
    logic [31:0] fetch_data_i = 32'h0;
    logic [31:0] wq[$];                             // drained write words
    int err_count = 0, num_checks = 0, nfetch = 0, fcnt = 0, early = 0, nf;
    always #10 clk_i = ~clk_i;
    hpsh_if port_if();
    hpsh_host i_hpsh_host(.clk_i, .srst_i, .req_i, .req_read_i, .req_ctl_i, .req_half_i,
        .req_hw_mode_i, .req_use_as_i, .req_data_i, .busy_o, .done_o, .rd_data_o,
        .port(port_if));
    hpsh_device i_hpsh_device(.clk_i, .srst_i, .port(port_if), .fetch_req_o, .fetch_ack_i,
        .fetch_data_i, .wr_valid_o, .wr_data_o, .wr_ready_i);
    hpsh_props i_hpsh_props(.clk_i, .srst_i,
        .port_chip_select_n(port_if.port_chip_select_n),
        .data_strobe_one_n(port_if.data_strobe_one_n),
        .data_strobe_two_n(port_if.data_strobe_two_n),
        .access_control_select(port_if.access_control_select),
        .read_write_select(port_if.read_write_select),
        .halfword_identifier(port_if.halfword_identifier),
        .halfword_bus_mode(port_if.halfword_bus_mode),
        .port_ready_n(port_if.port_ready_n),
        .dev_data_o(port_if.dev_data_o), .dev_data_oe_n(port_if.dev_data_oe_n));
    // fetch answer after a slow delay, counts early ready
    always @(posedge clk_i) begin
        fetch_ack_i <= 1'b0;
        if (fetch_req_o === 1'b1 && !fetch_ack_i) begin
            if (port_if.port_ready_n === 1'b0) early++;
            if (fcnt == 12) begin
                fetch_ack_i <= 1'b1;
                fetch_data_i <= fword;
                fcnt = 0;
                nfetch++;
            end else fcnt++;
        end
    end
    // write stream capture and stalling drain
    always @(posedge clk_i) begin
        if (!srst_i && wr_valid_o === 1'b1 && wr_ready_i) wq.push_back(wr_data_o);
        if (stall) wr_ready_i <= ~wr_ready_i;
    end
    // ------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic wt();
        int n;
        n = 0;
        while (done_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 400) chk_bit(1'bx, 1'b1);          // no completion seen
    endtask : wt
    task automatic acc(input logic rd, input logic [1:0] ctl, input logic half,
        input logic hw, input logic as_on, input logic [31:0] d, input logic wait_it);
        while (busy_o !== 1'b0) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        req_i <= 1'b1;
        req_read_i <= rd;
        req_ctl_i <= ctl;
        req_half_i <= half;
        req_hw_mode_i <= hw;
        req_use_as_i <= as_on;
        req_data_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        if (wait_it) wt();
    endtask : acc
    task automatic chk_pop(input logic [31:0] exp);
        int n;
        n = 0;
        while (wq.size() == 0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (wq.size() == 0) chk_bit(1'bx, 1'b1);     // nothing drained
        else chk_word(wq.pop_front(), exp);
    endtask : chk_pop
    task automatic end_test(input string name);
        $display("test %s done, checks %0d, errors %0d", name, num_checks, err_count);
    endtask : end_test
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // watchdog far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        $display("Error at %0t: run timed out", $time);
        finish_test();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int a = 0; a < 2; a++) begin
            fword = 32'hA5C3_0F10 + 32'(a);
            nf = nfetch;
            acc(1'b1, CTL_DATA_REG, 1'b0, 1'b0, a[0], 32'h0, 1'b1);
            chk_word(rd_data_o, fword);
            chk_word(32'(nfetch), 32'(nf + 1));
        end
        chk_word(32'(early), 32'h0);
        end_test("read32");
        for (int a = 0; a < 2; a++) begin
            fword = 32'h1234_ABCD ^ 32'(a);
            nf = nfetch;
            acc(1'b1, CTL_DATA_REG, 1'b0, 1'b1, a[0], 32'h0, 1'b1);
            chk_word({16'h0, rd_data_o[15:0]}, {16'h0, fword[15:0]});
            acc(1'b1, CTL_DATA_REG, 1'b1, 1'b1, a[0], 32'h0, 1'b1);
            chk_word({16'h0, rd_data_o[15:0]}, {16'h0, fword[31:16]});
            chk_word(32'(nfetch), 32'(nf + 1));
        end
        end_test("read16");
        acc(1'b0, CTL_DATA_REG, 1'b0, 1'b0, 1'b0, 32'hC0DE_0001, 1'b1);
        chk_pop(32'hC0DE_0001);
        acc(1'b0, CTL_DATA_REG, 1'b0, 1'b0, 1'b1, 32'hC0DE_0002, 1'b1);
        chk_pop(32'hC0DE_0002);
        acc(1'b0, CTL_DATA_REG, 1'b0, 1'b1, 1'b0, 32'h0000_BEEF, 1'b1);
        chk_word(32'(wq.size()), 32'h0);
        acc(1'b0, CTL_DATA_REG, 1'b1, 1'b1, 1'b1, 32'h0000_FACE, 1'b1);
        chk_pop(32'hFACE_BEEF);
        end_test("write");
        nf = nfetch;
        for (int c = 0; c < 3; c++) begin
            acc(1'b1, 2'(c), 1'b0, 1'b0, 1'b0, 32'h0, 1'b1);
            acc(1'b0, 2'(c), 1'b0, 1'b0, 1'b0, 32'h0F0F_0000, 1'b1);
        end
        chk_word(32'(nfetch), 32'(nf));
        wq.delete();
        end_test("codes");
        wr_ready_i <= 1'b0;
        for (int i = 0; i < 8; i++) acc(1'b0, CTL_DATA_REG, 1'b0, 1'b0, 1'b0, 32'h5A00_0000 + 32'(i), 1'b1);
        acc(1'b0, CTL_DATA_REG, 1'b0, 1'b0, 1'b0, 32'h5A00_0008, 1'b0);
        repeat (40) @(posedge clk_i);
        #1;
        chk_bit(port_if.port_ready_n, 1'b1);
        chk_bit(busy_o, 1'b1);
        stall <= 1'b1;
        wt();
        for (int i = 0; i < 9; i++) chk_pop(32'h5A00_0000 + 32'(i));
        @(posedge clk_i);
        stall <= 1'b0;
        @(posedge clk_i);
        wr_ready_i <= 1'b1;
        end_test("fill");
        finish_test();
    end
endmodule : hpsh_tb_top
`default_nettype wire
